// [design/chgsr_pkg.sv]
package chgsr_pkg;
  // register addresses
  localparam logic [7:0] CHGSR_COND_ADDR   = 8'h0a;
  localparam logic [7:0] CHGSR_RSTID_ADDR  = 8'h0b;
  // condition status field positions
  localparam int CHGSR_ATTACH_BIT   = 7;
  localparam int CHGSR_VLOOP_BIT    = 6;
  localparam int CHGSR_ILOOP_BIT    = 5;
  localparam int CHGSR_TOPOFF_BIT   = 3;
  localparam int CHGSR_OVP_BIT      = 2;
  localparam int CHGSR_VMASK_BIT    = 1;
  localparam int CHGSR_IMASK_BIT    = 0;
  // reset and identity field positions
  localparam int CHGSR_REGRST_BIT   = 7;
  localparam int CHGSR_PN_LSB       = 3;
  localparam int CHGSR_REV_LSB      = 0;
  // reset values
  localparam logic CHGSR_VMASK_RST  = 1'b0;
  localparam logic CHGSR_IMASK_RST  = 1'b0;
  // thermistor fault codes in boost mode
  localparam logic [2:0] CHGSR_NTC_NORMAL = 3'h0;
  localparam logic [2:0] CHGSR_NTC_COLD   = 3'h5;
  localparam logic [2:0] CHGSR_NTC_HOT    = 3'h6;
  // register reset sequence states
  typedef enum logic [1:0] {CHGSR_IDLE, CHGSR_CLEAR, CHGSR_DONE} chgsr_state_t;
endpackage

// [design/chgsr_edge.sv]
// one-cycle pulse on a rising edge of a loop flag, gated by its mask
module chgsr_edge
  import chgsr_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic level,
  input  wire logic mask,
  output logic      pulse
);
  logic prev_r;
  logic prev_nxt;

  // previous level
  always_comb begin
    prev_nxt = level;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // pulse only while unmasked
  assign pulse = level & ~prev_r & ~mask;
endmodule

// [design/chgsr_regs.sv]
// Functional notes
// - Bit 7 of the condition status register reads 1 while an input supply is attached.
// - Bit 6 of the condition status register reads 1 while the input-voltage loop is active.
// - Bit 5 of the condition status register reads 1 while the input-current loop is active.
// - Bit 3 of the condition status register reads 1 while the top-off timer is counting.
// - Bit 2 of the condition status register reads 1 while the input is in overvoltage.
// - Mask bit 1 blocks the voltage-loop interrupt pulse when 1, resets to 0.
// - Mask bit 0 blocks the current-loop interrupt pulse when 1, resets to 0.
// - Writing 1 to bit 7 of the reset register restores defaults and restarts the safety timer.
// - The register-reset bit clears itself once the reset is done, so later reads give 0.
// - In boost mode the thermistor fault field reads 101 for cold, 110 for hot, 000 normal.
module chgsr_regs
  import chgsr_pkg::*;
#(
  parameter logic [3:0] PART_NUMBER = 4'h9, // arbitrary value
  parameter logic [1:0] REVISION    = 2'h2  // arbitrary value
)(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       input_attached_flag,
  input  wire logic       input_voltage_loop_flag,
  input  wire logic       input_current_loop_flag,
  input  wire logic       topoff_counting_flag,
  input  wire logic       input_overvoltage_flag,
  input  wire logic       boost_mode,
  input  wire logic       ntc_cold,
  input  wire logic       ntc_hot,
  output logic      [2:0] thermistor_fault_field,
  output logic            voltage_loop_irq,
  output logic            current_loop_irq,
  output logic            defaults_restore,
  output logic            safety_timer_restart
);
  logic         vmask_r;
  logic         vmask_nxt;
  logic         imask_r;
  logic         imask_nxt;
  logic         regrst_r;
  logic         regrst_nxt;
  chgsr_state_t state_r;
  chgsr_state_t state_nxt;
  logic [7:0]   rdata_r;
  logic [7:0]   rdata_nxt;
  logic [2:0]   ntc_r;
  logic [2:0]   ntc_nxt;
  logic [7:0]   cond_val;
  logic [7:0]   rstid_val;
  logic         wr_cond;
  logic         wr_rst;
  // per-loop edge detector wiring, bit 1 voltage and bit 0 current
  localparam int LOOPS = 2;
  logic [1:0]   loop_level;
  logic [1:0]   loop_mask;
  logic [1:0]   loop_irq;

  assign wr_cond = reg_wr && (reg_addr == CHGSR_COND_ADDR);
  assign wr_rst  = reg_wr && (reg_addr == CHGSR_RSTID_ADDR) && reg_wdata[CHGSR_REGRST_BIT];

  // live read values, reserved bits zero
  always_comb begin
    cond_val = 8'h00;
    cond_val[CHGSR_ATTACH_BIT] = input_attached_flag;
    cond_val[CHGSR_VLOOP_BIT]  = input_voltage_loop_flag;
    cond_val[CHGSR_ILOOP_BIT]  = input_current_loop_flag;
    cond_val[CHGSR_TOPOFF_BIT] = topoff_counting_flag;
    cond_val[CHGSR_OVP_BIT]    = input_overvoltage_flag;
    cond_val[CHGSR_VMASK_BIT]  = vmask_r;
    cond_val[CHGSR_IMASK_BIT]  = imask_r;
    rstid_val = 8'h00;
    rstid_val[CHGSR_REGRST_BIT] = regrst_r;
    rstid_val[CHGSR_PN_LSB +: 4]  = PART_NUMBER;
    rstid_val[CHGSR_REV_LSB +: 2] = REVISION;
  end

  // register reset sequence and mask fields
  always_comb begin
    vmask_nxt  = vmask_r;
    imask_nxt  = imask_r;
    regrst_nxt = regrst_r;
    state_nxt  = state_r;
    unique case (state_r)
      CHGSR_IDLE: begin
        if (wr_rst) begin
          regrst_nxt = 1'b1;
          state_nxt  = CHGSR_CLEAR;
        end else if (wr_cond) begin
          // only the masks take write data
          vmask_nxt = reg_wdata[CHGSR_VMASK_BIT];
          imask_nxt = reg_wdata[CHGSR_IMASK_BIT];
        end
      end
      CHGSR_CLEAR: begin
        vmask_nxt = CHGSR_VMASK_RST;
        imask_nxt = CHGSR_IMASK_RST;
        state_nxt = CHGSR_DONE;
      end
      CHGSR_DONE: begin
        regrst_nxt = 1'b0;
        state_nxt  = CHGSR_IDLE;
      end
      // an illegal code drops back to idle
      default: begin
        regrst_nxt = 1'b0;
        state_nxt  = CHGSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      vmask_r  <= CHGSR_VMASK_RST;
      imask_r  <= CHGSR_IMASK_RST;
      regrst_r <= 1'b0;
      state_r  <= CHGSR_IDLE;
    end else begin
      vmask_r  <= vmask_nxt;
      imask_r  <= imask_nxt;
      regrst_r <= regrst_nxt;
      state_r  <= state_nxt;
    end
  end

  assign defaults_restore     = (state_r == CHGSR_CLEAR);
  assign safety_timer_restart = (state_r == CHGSR_CLEAR);

  // read data and thermistor field registered
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      if (reg_addr == CHGSR_COND_ADDR) begin
        rdata_nxt = cond_val;
      end else if (reg_addr == CHGSR_RSTID_ADDR) begin
        rdata_nxt = rstid_val;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
    ntc_nxt = CHGSR_NTC_NORMAL;
    if (boost_mode && ntc_cold) begin
      ntc_nxt = CHGSR_NTC_COLD;
    end else if (boost_mode && ntc_hot) begin
      ntc_nxt = CHGSR_NTC_HOT;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
      ntc_r   <= CHGSR_NTC_NORMAL;
    end else begin
      rdata_r <= rdata_nxt;
      ntc_r   <= ntc_nxt;
    end
  end

  assign reg_rdata              = rdata_r;
  assign thermistor_fault_field = ntc_r;

  // loop levels and masks packed per loop, bit 1 voltage and bit 0 current
  assign loop_level = {input_voltage_loop_flag, input_current_loop_flag};
  assign loop_mask  = {vmask_r, imask_r};

  // one edge detector per regulation loop, gated by its own mask bit
  for (genvar g = 0; g < LOOPS; g++) begin : g_loop_edge
    chgsr_edge chgsr_edge_i (
      .mclk  (mclk),
      .rst_b (rst_b),
      .level (loop_level[g]),
      .mask  (loop_mask[g]),
      .pulse (loop_irq[g])
    );
  end

  // interrupt pulses back out on their own ports
  assign voltage_loop_irq = loop_irq[1];
  assign current_loop_irq = loop_irq[0];

  // register reset steps: request, busy cycle with both restore pulses, then self-clear
  sequence s_reset_request;
    wr_rst && state_r == CHGSR_IDLE;
  endsequence

  sequence s_reset_busy;
    regrst_r && defaults_restore && safety_timer_restart;
  endsequence

  sequence s_reset_finish;
    regrst_r && !defaults_restore ##1 !regrst_r;
  endsequence

  // register read requests, answered on the following edge
  sequence s_status_read;
    reg_rd && reg_addr == CHGSR_COND_ADDR;
  endsequence

  sequence s_ident_read;
    reg_rd && reg_addr == CHGSR_RSTID_ADDR;
  endsequence

  // the reset bit clears itself two cycles after it rose
  a_rst_selfclear: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(regrst_r) |-> ##2 !regrst_r)
    else $error("reset bit did not clear");

  // a reset request walks through its steps in order
  a_rst_steps: assert property (@(posedge mclk) disable iff (!rst_b)
    s_reset_request |=> s_reset_busy ##1 s_reset_finish)
    else $error("reset steps out of order");

  // masks are back at their defaults once the busy cycle is over
  a_rst_defaults: assert property (@(posedge mclk) disable iff (!rst_b)
    s_reset_request |-> ##2 (!vmask_r && !imask_r))
    else $error("masks not defaulted");

  // the safety timer restart follows the request by one cycle
  a_rst_timer: assert property (@(posedge mclk) disable iff (!rst_b)
    s_reset_request |=> safety_timer_restart)
    else $error("timer not restarted");

  // restore and timer pulses last a single cycle
  a_restore_single: assert property (@(posedge mclk) disable iff (!rst_b)
    defaults_restore |=> !defaults_restore)
    else $error("restore pulse too long");
  a_timer_single: assert property (@(posedge mclk) disable iff (!rst_b)
    safety_timer_restart |=> !safety_timer_restart)
    else $error("timer pulse too long");

  // mask writes that arrive while the reset finishes are dropped
  a_rst_ignore: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == CHGSR_DONE |=> $stable(vmask_r) && $stable(imask_r))
    else $error("mask changed during reset");

  // a status write lands in the two mask bits
  a_mask_write: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_cond && state_r == CHGSR_IDLE |=> vmask_r == $past(reg_wdata[CHGSR_VMASK_BIT])
      && imask_r == $past(reg_wdata[CHGSR_IMASK_BIT]))
    else $error("mask write lost");

  // a set mask keeps its loop pulse low
  a_vmask_gate: assert property (@(posedge mclk) disable iff (!rst_b)
    vmask_r |-> !voltage_loop_irq)
    else $error("voltage irq not masked");
  a_imask_gate: assert property (@(posedge mclk) disable iff (!rst_b)
    imask_r |-> !current_loop_irq)
    else $error("current irq not masked");

  // a clear mask lets a rising loop flag through in the same cycle
  a_vloop_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(input_voltage_loop_flag) && !vmask_r |-> voltage_loop_irq)
    else $error("voltage irq missing");
  a_iloop_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(input_current_loop_flag) && !imask_r |-> current_loop_irq)
    else $error("current irq missing");

  // a loop pulse never lasts beyond one cycle
  a_vloop_single: assert property (@(posedge mclk) disable iff (!rst_b)
    voltage_loop_irq |=> !voltage_loop_irq)
    else $error("voltage irq too long");
  a_iloop_single: assert property (@(posedge mclk) disable iff (!rst_b)
    current_loop_irq |=> !current_loop_irq)
    else $error("current irq too long");

  // status reads return the live flags, the masks and a zero reserved bit
  a_status_read: assert property (@(posedge mclk) disable iff (!rst_b)
    s_status_read |=> reg_rdata[7:5] == $past(cond_val[7:5]))
    else $error("status read wrong");
  a_flags_read: assert property (@(posedge mclk) disable iff (!rst_b)
    s_status_read |=> reg_rdata[3:2] == $past({topoff_counting_flag, input_overvoltage_flag})
      && !reg_rdata[4])
    else $error("flag read wrong");
  a_masks_read: assert property (@(posedge mclk) disable iff (!rst_b)
    s_status_read |=> reg_rdata[1:0] == $past({vmask_r, imask_r}))
    else $error("mask read wrong");

  // identity reads return the fixed codes and the reset bit
  a_ident_read: assert property (@(posedge mclk) disable iff (!rst_b)
    s_ident_read |=> reg_rdata[6:0] == {PART_NUMBER, 1'b0, REVISION})
    else $error("identity read wrong");
  a_regrst_read: assert property (@(posedge mclk) disable iff (!rst_b)
    s_ident_read |=> reg_rdata[7] == $past(regrst_r))
    else $error("reset bit read wrong");

  // other addresses read as zero, and read data stands until the next read
  a_unmapped_read: assert property (@(posedge mclk) disable iff (!rst_b)
    reg_rd && reg_addr != CHGSR_COND_ADDR && reg_addr != CHGSR_RSTID_ADDR |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_read_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed");

  // thermistor field codes, cold winning over hot, normal otherwise
  a_ntc_cold: assert property (@(posedge mclk) disable iff (!rst_b)
    boost_mode && ntc_cold |=> thermistor_fault_field == CHGSR_NTC_COLD)
    else $error("cold code wrong");
  a_ntc_hot: assert property (@(posedge mclk) disable iff (!rst_b)
    boost_mode && ntc_hot && !ntc_cold |=> thermistor_fault_field == CHGSR_NTC_HOT)
    else $error("hot code wrong");
  a_ntc_normal: assert property (@(posedge mclk) disable iff (!rst_b)
    !boost_mode || (!ntc_cold && !ntc_hot) |=> thermistor_fault_field == CHGSR_NTC_NORMAL)
    else $error("normal code wrong");
endmodule

// [tb/chgsr_host.sv]
// host side model driving single-byte register cycles
module chgsr_host
  import chgsr_pkg::*;
(
  input  wire logic       mclk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // write strobe held over one edge, data inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk) #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // read strobe over one edge, data taken a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk) #1;
    reg_rd = 1'b0;
    @(posedge mclk) #1;
    d = reg_rdata;
  endtask
  // only the two mask bits are written in the status register
  task automatic mask(input logic [1:0] m);
    wr(CHGSR_COND_ADDR, {6'h00, m});
  endtask
endmodule

// [tb/tb_charger_status_reset_regs.sv]
module tb_charger_status_reset_regs;
  import chgsr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk = 1'b0;
  logic       rst_b;
  logic [7:0] addr, wdata, rdata, d;
  logic       wr, rd, boost, cold, hot, virq, cirq, dres, strt;
  logic [4:0] st;
  logic [2:0] tf;
  int         errors, checks, nv, ni, nd, ns, cyc;
  always #12.5 mclk = ~mclk;
  chgsr_host chgsr_host_i (.mclk(mclk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
    .reg_rdata(rdata));
  chgsr_regs #(.PART_NUMBER(4'h5), .REVISION(2'h1)) chgsr_regs_i (.mclk(mclk), .rst_b(rst_b),
    .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
    .input_attached_flag(st[4]), .input_voltage_loop_flag(st[3]), .input_current_loop_flag(st[2]),
    .topoff_counting_flag(st[1]), .input_overvoltage_flag(st[0]), .boost_mode(boost), .ntc_cold(cold),
    .ntc_hot(hot), .thermistor_fault_field(tf), .voltage_loop_irq(virq), .current_loop_irq(cirq),
    .defaults_restore(dres), .safety_timer_restart(strt));
  // pulse counters and run limit
  always @(posedge mclk) begin
    nv += int'(virq === 1'b1);
    ni += int'(cirq === 1'b1);
    nd += int'(dres === 1'b1);
    ns += int'(strt === 1'b1);
    cyc++;
    if (cyc == 3000) begin
      errors++;
      print_verdict;
    end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // each flag alone, after a refused write of status bits
  task automatic t_status;
    int p[5] = '{CHGSR_OVP_BIT, CHGSR_TOPOFF_BIT, CHGSR_ILOOP_BIT, CHGSR_VLOOP_BIT, CHGSR_ATTACH_BIT};
    chgsr_host_i.rd(CHGSR_COND_ADDR, d);
    chk("power-up", d & 8'hef, 8'h00);
    chgsr_host_i.wr(CHGSR_COND_ADDR, 8'hfc);
    for (int i = 0; i < 5; i++) begin
      st = 5'h01 << i;
      chgsr_host_i.rd(CHGSR_COND_ADDR, d);
      chk("status", d & 8'hef, 8'h01 << p[i]);
    end
    st = 5'h00;
    $display("t_status done");
  endtask
  // each mask blocks only its own loop pulse
  task automatic t_mask;
    for (int m = 1; m < 3; m++) begin
      chgsr_host_i.mask(2'(m));
      nv = 0;
      ni = 0;
      st = 5'h0c;
      repeat (3) @(posedge mclk);
      #1 st = 5'h00;
      chk("vloop irq", 8'(nv), 8'(m == 1));
      chk("iloop irq", 8'(ni), 8'(m == 2));
    end
    chgsr_host_i.rd(CHGSR_COND_ADDR, d);
    chk("masks", d & 8'h03, 8'h02);
    $display("t_mask done");
  endtask
  // zero keeps settings, one restores defaults and self-clears
  task automatic t_reset;
    chgsr_host_i.mask(2'h3);
    chgsr_host_i.wr(CHGSR_RSTID_ADDR, 8'h00);
    chgsr_host_i.rd(CHGSR_COND_ADDR, d);
    chk("kept masks", d & 8'h03, 8'h03);
    nd = 0;
    ns = 0;
    chgsr_host_i.wr(CHGSR_RSTID_ADDR, 8'h80);
    chgsr_host_i.rd(CHGSR_RSTID_ADDR, d);
    chk("reset bit set", d & 8'h80, 8'h80);
    repeat (2) @(posedge mclk);
    chgsr_host_i.rd(CHGSR_RSTID_ADDR, d);
    chk("reset bit", d & 8'h80, 8'h00);
    chk("restore", 8'(nd), 8'h01);
    chk("timer", 8'(ns), 8'h01);
    chgsr_host_i.rd(CHGSR_COND_ADDR, d);
    chk("masks cleared", d & 8'h03, 8'h00);
    $display("t_reset done");
  endtask
  // identity fields ignore writes, unmapped reads give zero
  task automatic t_ident;
    chgsr_host_i.wr(CHGSR_RSTID_ADDR, 8'h7f);
    chgsr_host_i.rd(CHGSR_RSTID_ADDR, d);
    chk("identity", d & 8'hfb, 8'h29);
    chgsr_host_i.rd(8'h00, d);
    chk("unmapped", d, 8'h00);
    $display("t_ident done");
  endtask
  // every boost, cold and hot combination
  task automatic t_ntc;
    for (int k = 0; k < 8; k++) begin
      {boost, cold, hot} = 3'(k);
      repeat (2) @(posedge mclk);
      #1 chk("ntc", {5'h00, tf}, k == 6 || k == 7 ? 8'h05 : k == 5 ? 8'h06 : 8'h00);
    end
    $display("t_ntc done");
  endtask
  initial begin
    rst_b = 1'b0;
    st = 5'h00;
    {boost, cold, hot} = 3'h0;
    repeat (6) @(posedge mclk);
    #1 rst_b = 1'b1;
    t_status;
    t_mask;
    t_reset;
    t_ident;
    t_ntc;
    print_verdict;
  end
endmodule
